// *** ssr_pkg.sv ***
// Constants of the status reporting summary block
package ssr_pkg;
  // Status summary byte positions
  localparam int BIT_TRIG   = 0;
  localparam int BIT_ADVIS  = 2;
  localparam int BIT_REPLY  = 4;
  localparam int BIT_EVSUM  = 5;
  localparam int BIT_RQS    = 6;
  localparam int BIT_ACT    = 7;
  // Standard event register positions
  localparam int EV_OPS     = 0;
  localparam int EV_CTRL    = 1;
  localparam int EV_QUERY   = 2;
  localparam int EV_DEVICE  = 3;
  localparam int EV_RANGE   = 4;
  localparam int EV_PARSE   = 5;
  localparam int EV_USER    = 6;
  localparam int EV_POWER   = 7;
  // Operation status positions
  localparam int OP_RUN     = 3;
  localparam int OP_ARMED   = 5;
  localparam int OP_OVLD    = 11;
  // Reset values
  localparam logic [7:0]  STD_RST  = 8'h80;
  localparam logic [7:0]  MASK_RST = 8'h00;
  localparam logic [15:0] OPM_RST  = 16'h0000;
endpackage

// *** ssr_status_reporting.sv ***
// Status reporting summary byte and service request logic
`timescale 1ns/100ps
module ssr_status_reporting (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        opsFinishedEvt,
  input  wire logic        controlRequestEvt,
  input  wire logic        queryProtocolFaultEvt,
  input  wire logic        deviceSpecificFaultEvt,
  input  wire logic        rangeFaultEvt,
  input  wire logic        parseFaultEvt,
  input  wire logic        userKeyEvt,
  input  wire logic        triggerEvt,
  input  wire logic        runningIn,
  input  wire logic        armedIn,
  input  wire logic        inputOverloadIn,
  input  wire logic        advisoryPending,
  input  wire logic        replyPending,
  input  wire logic        clearStatus,
  input  wire logic        clearAfterTerminator,
  input  wire logic        eventEnableWr,
  input  wire logic [7:0]  eventEnableData,
  input  wire logic        serviceEnableWr,
  input  wire logic [7:0]  serviceEnableData,
  input  wire logic        opEnableWr,
  input  wire logic [15:0] opEnableData,
  input  wire logic        stdEventRead,
  input  wire logic        opStatusRead,
  input  wire logic        triggerRead,
  input  wire logic        serialPoll,
  input  wire logic        byteQuery,
  output logic [7:0]       pollData,
  output logic [7:0]       queryData,
  output logic [7:0]       stdEventData,
  output logic [15:0]      opStatusData,
  output logic             triggerData,
  output logic [7:0]       eventEnable,
  output logic [7:0]       serviceEnable,
  output logic [15:0]      opEnable,
  output logic             clearOutputQueue,
  output logic             clearOtherQueues,
  output logic             serviceRequestN
);
  logic [7:0]  stdEvent_ff, nxt_stdEvent;
  logic [15:0] opStatus_ff, nxt_opStatus;
  logic        trig_ff, nxt_trig;
  logic        rqs_ff, nxt_rqs;
  logic        mssPrev_ff, nxt_mssPrev;
  logic [7:0]  evEn_ff, nxt_evEn;
  logic [7:0]  srEn_ff, nxt_srEn;
  logic [15:0] opEn_ff, nxt_opEn;
  logic [7:0]  poll_ff, nxt_poll;
  logic [7:0]  query_ff, nxt_query;
  logic [7:0]  stdRd_ff, nxt_stdRd;
  logic [15:0] opRd_ff, nxt_opRd;
  logic        trigRd_ff, nxt_trigRd;
  logic        clrOq_ff, nxt_clrOq;
  logic        clrQ_ff, nxt_clrQ;
  logic [7:0]  stdSet;
  logic [15:0] opSet;
  logic [7:0]  summary;
  logic        master_summary;

  // Event sources into the standard event and operation status registers
  always_comb begin
    stdSet                       = '0;
    stdSet[ssr_pkg::EV_OPS]      = opsFinishedEvt;
    stdSet[ssr_pkg::EV_CTRL]     = controlRequestEvt;
    stdSet[ssr_pkg::EV_QUERY]    = queryProtocolFaultEvt;
    stdSet[ssr_pkg::EV_DEVICE]   = deviceSpecificFaultEvt;
    stdSet[ssr_pkg::EV_RANGE]    = rangeFaultEvt;
    stdSet[ssr_pkg::EV_PARSE]    = parseFaultEvt;
    stdSet[ssr_pkg::EV_USER]     = userKeyEvt;
    opSet                        = '0;
    opSet[ssr_pkg::OP_RUN]       = runningIn;
    opSet[ssr_pkg::OP_ARMED]     = armedIn;
    opSet[ssr_pkg::OP_OVLD]      = inputOverloadIn;
  end

  // Live summary byte, bit 6 as master summary
  always_comb begin
    summary                     = '0;
    summary[ssr_pkg::BIT_TRIG]  = trig_ff;
    summary[ssr_pkg::BIT_ADVIS] = advisoryPending;
    summary[ssr_pkg::BIT_REPLY] = replyPending;
    summary[ssr_pkg::BIT_EVSUM] = |(stdEvent_ff & evEn_ff);
    summary[ssr_pkg::BIT_ACT]   = |(opStatus_ff & opEn_ff);
    master_summary = |(summary & srEn_ff & ~(8'h01 << ssr_pkg::BIT_RQS));
    summary[ssr_pkg::BIT_RQS]   = master_summary;
  end

  // Next-state computation
  always_comb begin
    // Sticky sets win over clears
    nxt_stdEvent = stdEvent_ff;
    nxt_opStatus = opStatus_ff;
    nxt_trig     = trig_ff;
    if (stdEventRead) begin
      nxt_stdEvent = '0;
    end
    if (opStatusRead) begin
      nxt_opStatus = '0;
    end
    if (triggerRead) begin
      nxt_trig = 1'b0;
    end
    if (clearStatus) begin
      nxt_stdEvent = '0;
      nxt_opStatus = '0;
      nxt_trig     = 1'b0;
    end
    nxt_stdEvent = nxt_stdEvent | stdSet;
    nxt_opStatus = nxt_opStatus | opSet;
    nxt_trig     = nxt_trig | triggerEvt;
    nxt_evEn = eventEnableWr ? eventEnableData : evEn_ff;
    nxt_srEn = serviceEnableWr ? serviceEnableData : srEn_ff;
    nxt_opEn = opEnableWr ? opEnableData : opEn_ff;
    // Request flag raised on rising master summary, dropped by poll or when master summary is low
    nxt_mssPrev = master_summary;
    nxt_rqs     = rqs_ff;
    if (master_summary && !mssPrev_ff) begin
      nxt_rqs = 1'b1;
    end
    if (!master_summary) begin
      nxt_rqs = 1'b0;
    end
    if (serialPoll) begin
      nxt_rqs = 1'b0;
    end
    nxt_poll = poll_ff;
    if (serialPoll) begin
      nxt_poll = summary;
      nxt_poll[ssr_pkg::BIT_RQS] = rqs_ff;
    end
    nxt_query   = byteQuery ? summary : query_ff;
    nxt_stdRd   = stdEventRead ? stdEvent_ff : stdRd_ff;
    nxt_opRd    = opStatusRead ? opStatus_ff : opRd_ff;
    nxt_trigRd  = triggerRead ? trig_ff : trigRd_ff;
    nxt_clrQ    = clearStatus;
    nxt_clrOq   = clearStatus && clearAfterTerminator;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      stdEvent_ff <= ssr_pkg::STD_RST;
      opStatus_ff <= ssr_pkg::OPM_RST;
      trig_ff     <= 1'b0;
      rqs_ff      <= 1'b0;
      mssPrev_ff  <= 1'b0;
      evEn_ff     <= ssr_pkg::MASK_RST;
      srEn_ff     <= ssr_pkg::MASK_RST;
      opEn_ff     <= ssr_pkg::OPM_RST;
      poll_ff     <= '0;
      query_ff    <= '0;
      stdRd_ff    <= '0;
      opRd_ff     <= '0;
      trigRd_ff   <= 1'b0;
      clrOq_ff    <= 1'b0;
      clrQ_ff     <= 1'b0;
    end else begin
      stdEvent_ff <= nxt_stdEvent;
      opStatus_ff <= nxt_opStatus;
      trig_ff     <= nxt_trig;
      rqs_ff      <= nxt_rqs;
      mssPrev_ff  <= nxt_mssPrev;
      evEn_ff     <= nxt_evEn;
      srEn_ff     <= nxt_srEn;
      opEn_ff     <= nxt_opEn;
      poll_ff     <= nxt_poll;
      query_ff    <= nxt_query;
      stdRd_ff    <= nxt_stdRd;
      opRd_ff     <= nxt_opRd;
      trigRd_ff   <= nxt_trigRd;
      clrOq_ff    <= nxt_clrOq;
      clrQ_ff     <= nxt_clrQ;
    end
  end

  assign pollData         = poll_ff;
  assign queryData        = query_ff;
  assign stdEventData     = stdRd_ff;
  assign opStatusData     = opRd_ff;
  assign triggerData      = trigRd_ff;
  assign eventEnable      = evEn_ff;
  assign serviceEnable    = srEn_ff;
  assign opEnable         = opEn_ff;
  assign clearOutputQueue = clrOq_ff;
  assign clearOtherQueues = clrQ_ff;
  assign serviceRequestN  = ~rqs_ff;
endmodule

// *** ssr_status_reporting_props.sv ***
// Port assertions for the status reporting block
`timescale 1ns/100ps
module ssr_status_props (
  input logic        clk,
  input logic        rst,
  input logic        triggerEvt,
  input logic        runningIn,
  input logic        replyPending,
  input logic        clearStatus,
  input logic        clearAfterTerminator,
  input logic        opStatusRead,
  input logic        triggerRead,
  input logic        serialPoll,
  input logic        byteQuery,
  input logic [7:0]  pollData,
  input logic [7:0]  queryData,
  input logic [15:0] opStatusData,
  input logic        triggerData,
  input logic [7:0]  serviceEnable,
  input logic        clearOutputQueue,
  input logic        clearOtherQueues,
  input logic        serviceRequestN
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence runThenRead;
    runningIn ##1 opStatusRead;
  endsequence
  sequence trigThenRead;
    triggerEvt ##1 !(triggerRead || clearStatus) ##1 triggerRead;
  endsequence
  poll_frees_srq_a: assert property (serialPoll |=> serviceRequestN)
    else $error("srq held after poll");
  poll_flag_a: assert property (serialPoll |=> pollData[6] == !$past(serviceRequestN))
    else $error("poll bit6 wrong");
  query_mss_a: assert property (byteQuery |=>
    queryData[6] == |({queryData[7], 1'b0, queryData[5:0]} & $past(serviceEnable)))
    else $error("query bit6 wrong");
  srq_masked_a: assert property ((serviceEnable == 8'h00)[*2] |-> serviceRequestN)
    else $error("srq without enable");
  cls_pulse_a: assert property (clearStatus |=> clearOtherQueues &&
    clearOutputQueue == $past(clearAfterTerminator))
    else $error("clear pulses wrong");
  reply_live_a: assert property (byteQuery |=> queryData[4] == $past(replyPending))
    else $error("reply bit wrong");
  run_sticky_a: assert property (runThenRead |=> opStatusData[3])
    else $error("running bit lost");
  trig_sticky_a: assert property (trigThenRead |=> triggerData)
    else $error("trigger bit lost");
endmodule
bind ssr_status_reporting ssr_status_props u_props (.*);

// *** ssr_ctrl_model.sv ***
// Controller model that answers the request line with a serial poll
`timescale 1ns/100ps
module ssr_ctrl_model (
  input  logic       clk,
  input  logic       serviceRequestN,
  input  logic       pollEn,
  input  logic [3:0] lag,
  output logic       serialPoll
);
  logic [3:0] waitCnt = 4'h0;
  initial serialPoll = 1'b0;
  always @(posedge clk) begin
    waitCnt <= (serviceRequestN || serialPoll) ? 4'h0 : waitCnt + 4'h1;
    if (pollEn && !serviceRequestN && !serialPoll && waitCnt >= lag) begin
      serialPoll <= #2 1'b1;
    end else begin
      serialPoll <= #2 1'b0;
    end
  end
endmodule

// *** testbench.sv ***
// Bench for the status reporting block with a polling controller
`timescale 1ns/100ps
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        term = 1'b0;
  logic        pollEn = 1'b0;
  logic [3:0]  lag = 4'h3;
  logic [2:0]  lvl = 3'h0;
  logic [1:0]  q = 2'h0;
  logic [15:0] st = 16'h0000;
  logic [15:0] wd = 16'h0000;
  logic [15:0] opStatusData, opEnable;
  logic [7:0]  pollData, queryData, stdEventData, eventEnable, serviceEnable;
  logic        serialPoll, triggerData, clearOutputQueue, clearOtherQueues, serviceRequestN;
  int          n_mismatch = 0;
  int          num_checks = 0;
  always #10 clk = ~clk;
  ssr_status_reporting u_dut (.*, .opsFinishedEvt(st[0]), .controlRequestEvt(st[1]),
    .queryProtocolFaultEvt(st[2]), .deviceSpecificFaultEvt(st[3]), .rangeFaultEvt(st[4]),
    .parseFaultEvt(st[5]), .userKeyEvt(st[6]), .triggerEvt(st[7]), .clearStatus(st[8]),
    .stdEventRead(st[9]), .opStatusRead(st[10]), .triggerRead(st[11]), .byteQuery(st[12]),
    .eventEnableWr(st[13]), .serviceEnableWr(st[14]), .opEnableWr(st[15]),
    .runningIn(lvl[0]), .armedIn(lvl[1]), .inputOverloadIn(lvl[2]), .advisoryPending(q[0]),
    .replyPending(q[1]), .clearAfterTerminator(term), .eventEnableData(wd[7:0]),
    .serviceEnableData(wd[7:0]), .opEnableData(wd));
  ssr_ctrl_model u_ctrl (.*);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic hit(input logic [15:0] s, input logic [15:0] d = 16'h0000);
    cyc(1);
    st = s;
    wd = d;
    cyc(1);
    st = 16'h0000;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic waitPoll;
    for (int i = 0; i < 40 && serialPoll !== 1'b1; i++) cyc(1);
    if (serialPoll !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: no serial poll", $time);
      test_done;
    end
    cyc(1);
  endtask
  initial begin
    cyc(12);
    rst = 1'b0;
    hit(16'h0200);
    chk(stdEventData, 8'h80);
    for (int i = 0; i < 7; i++) begin
      hit(16'h0001 << i);
      cyc(3);
      hit(16'h0200);
      chk(stdEventData, 8'h01 << i);
    end
    hit(16'h2000, 16'h0004);
    hit(16'h4000, 16'h0020);
    chk(eventEnable, 8'h04);
    chk(serviceEnable, 8'h20);
    hit(16'h0004);
    cyc(1);
    chk(serviceRequestN, 1'b0);
    hit(16'h1000);
    chk({serviceRequestN, queryData}, 9'h060);
    pollEn = 1'b1;
    waitPoll;
    chk({serviceRequestN, pollData}, 9'h160);
    lag = 4'h0;
    hit(16'h0200);
    hit(16'h0004);
    waitPoll;
    chk(pollData, 8'h60);
    pollEn = 1'b0;
    q = 2'b10;
    hit(16'h4000);
    hit(16'h1000);
    chk({serviceRequestN, queryData}, 9'h130);
    q = 2'b01;
    hit(16'h1000);
    chk(queryData, 8'h24);
    hit(16'h0080);
    hit(16'h0800);
    chk(triggerData, 1'b1);
    hit(16'h8000, 16'h0828);
    chk(opEnable, 16'h0828);
    lvl = 3'b111;
    hit(16'h0400);
    chk(opStatusData, 16'h0828);
    hit(16'h1000);
    chk(queryData, 8'hA4);
    lvl = 3'b000;
    hit(16'h0400);
    hit(16'h1000);
    chk(queryData, 8'h24);
    term = 1'b1;
    hit(16'h0100);
    chk({clearOutputQueue, clearOtherQueues}, 2'b11);
    term = 1'b0;
    hit(16'h0100);
    chk({clearOutputQueue, clearOtherQueues}, 2'b01);
    hit(16'h1000);
    chk(queryData, 8'h04);
    test_done;
  end
endmodule
